//--- core/mpu_interrupt_aggregator.sv
`timescale 1ns/1ns
module mpu_interrupt_aggregator
  import mpu_irq_pkg::*;
#(
  parameter int unsigned DIO_W = 8,
  parameter int unsigned SEL_W = 3
) (
  input  wire logic              ref_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic [ADDR_W-1:0] sfr_addr_in,
  input  wire logic              sfr_wr_in,
  input  wire logic              sfr_rd_in,
  input  wire logic [DATA_W-1:0] sfr_wdata_in,
  output logic      [DATA_W-1:0] sfr_rdata_out,
  input  wire logic [DIO_W-1:0]  dio_pins_in,
  input  wire logic [SEL_W-1:0]  ext0_pin_select_in,
  input  wire logic [SEL_W-1:0]  ext1_pin_select_in,
  input  wire logic [3:0]        ce_pulse_in,
  input  wire logic              ce_busy_in,
  input  wire logic [2:0]        voltage_status_in,
  input  wire logic              eeprom_busy_in,
  input  wire logic              serial_periph_event_in,
  input  wire logic              transfer_busy_in,
  input  wire logic              clock_second_tick_in,
  input  wire logic              clock_minute_tick_in,
  input  wire logic              clock_alarm_in,
  input  wire logic              timer_a_overflow_in,
  input  wire logic              timer_b_overflow_in,
  input  wire logic              timer_a_service_ack_in,
  input  wire logic              timer_b_service_ack_in,
  input  wire logic              serial0_req_in,
  input  wire logic              serial1_req_in,
  input  wire logic              irq_ack_in,
  input  wire logic              irq_return_in,
  output logic                   irq_req_out,
  output logic      [VEC_W-1:0]  irq_vector_out,
  output logic      [SRC_W-1:0]  irq_source_out,
  output logic      [LVL_W-1:0]  irq_level_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] tcon_q, tcon_d, en0_q, en1_q, en2_q, ipl_q, iph_q;
  logic [7:0] ext_flags_q, ext_flags_d, edge_sel_q, sub_a_q, sub_a_d;
  logic [7:0] sub_b_q, sub_b_d, sub_en_a_q, sub_en_b_q;
  logic [7:0] rdata_q;
  logic [DIO_W-1:0] dio_meta_q, dio_sync_q;
  logic       ext0_pin_q, ext1_pin_q;
  logic [3:0] pulse_q;
  logic       busy_q, eeprom_q, spi_q;
  logic [2:0] volt_q;
  logic [3:0] ext6_src_q;
  logic [NUM_LVL-1:0] in_service_q;
  logic              irq_req_q;
  logic [VEC_W-1:0]  vector_q;
  logic [SRC_W-1:0]  src_q;
  logic [LVL_W-1:0]  level_q;

  logic wr_tcon, wr_en0, wr_en1, wr_en2, wr_ipl, wr_iph, wr_ext_flags;
  logic wr_edge, wr_sub_a, wr_sub_b, wr_sub_en_a, wr_sub_en_b;

  // Strobe and address are arguments, not signals read from inside,
  // so that each write decode is re-evaluated whenever they move.
  function automatic logic hit(input logic              wr,
                               input logic [ADDR_W-1:0] addr,
                               input logic [ADDR_W-1:0] a);
    hit = wr && (addr == a);
  endfunction

  function automatic logic [VEC_W-1:0] vector_of(input logic [3:0] s);
    case (s)
      SRC_EXT0: vector_of = VEC_EXT0;
      SRC_SER1: vector_of = VEC_SER1;
      SRC_TMR0: vector_of = VEC_TMR0;
      SRC_EXT2: vector_of = VEC_EXT2;
      SRC_EXT1: vector_of = VEC_EXT1;
      SRC_EXT3: vector_of = VEC_EXT3;
      SRC_TMR1: vector_of = VEC_TMR1;
      SRC_EXT4: vector_of = VEC_EXT4;
      SRC_SER0: vector_of = VEC_SER0;
      SRC_EXT5: vector_of = VEC_EXT5;
      default:  vector_of = VEC_EXT6;
    endcase
  endfunction

  assign wr_tcon      = hit(sfr_wr_in, sfr_addr_in, ADDR_TIMER_EXT_CTRL);
  assign wr_en0       = hit(sfr_wr_in, sfr_addr_in, ADDR_ENABLE_0);
  assign wr_en1       = hit(sfr_wr_in, sfr_addr_in, ADDR_ENABLE_1);
  assign wr_en2       = hit(sfr_wr_in, sfr_addr_in, ADDR_ENABLE_2);
  assign wr_ipl       = hit(sfr_wr_in, sfr_addr_in, ADDR_PRIORITY_LOW);
  assign wr_iph       = hit(sfr_wr_in, sfr_addr_in, ADDR_PRIORITY_HIGH);
  assign wr_ext_flags = hit(sfr_wr_in, sfr_addr_in, ADDR_EXT_REQ_FLAGS);
  assign wr_edge      = hit(sfr_wr_in, sfr_addr_in, ADDR_TIMER_C_CONTROL);
  assign wr_sub_a     = hit(sfr_wr_in, sfr_addr_in, ADDR_SUB_FLAGS_A);
  assign wr_sub_b     = hit(sfr_wr_in, sfr_addr_in, ADDR_SUB_FLAGS_B);
  assign wr_sub_en_a  = hit(sfr_wr_in, sfr_addr_in, ADDR_SUB_ENABLES_A);
  assign wr_sub_en_b  = hit(sfr_wr_in, sfr_addr_in, ADDR_SUB_ENABLES_B);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      // Idle high, like the pin history, so no false event after reset.
      dio_meta_q <= '1;
      dio_sync_q <= '1;
    end else begin
      dio_meta_q <= dio_pins_in;
      dio_sync_q <= dio_meta_q;
    end
  end

  logic ext0_pin, ext1_pin;
  assign ext0_pin = dio_sync_q[ext0_pin_select_in];
  assign ext1_pin = dio_sync_q[ext1_pin_select_in];

  // Inverted copies so that every ext6 sub-source is a rising edge.
  logic [3:0] ext6_src;
  assign ext6_src = ~{clock_alarm_in, clock_minute_tick_in,
                      clock_second_tick_in, transfer_busy_in};

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      ext0_pin_q <= 1'b1;
      ext1_pin_q <= 1'b1;
      pulse_q    <= '0;
      busy_q     <= 1'b0;
      volt_q     <= '0;
      eeprom_q   <= 1'b0;
      spi_q      <= 1'b0;
      ext6_src_q <= '1;
    end else begin
      ext0_pin_q <= ext0_pin;
      ext1_pin_q <= ext1_pin;
      pulse_q    <= ce_pulse_in;
      busy_q     <= ce_busy_in;
      volt_q     <= voltage_status_in;
      eeprom_q   <= eeprom_busy_in;
      spi_q      <= serial_periph_event_in;
      ext6_src_q <= ext6_src;
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic       ext0_ev, ext1_ev, ext2_ev, ext3_ev, ext4_ev, ext5_ev;
  logic       ext6_ev, eeprom_fall, spi_rise;
  logic [3:0] pulse_edge, pulse_en, ext6_edge, ext6_en;

  // Type bit high selects falling edge, low selects low level.
  assign ext0_ev = tcon_q[B_IT0] ? (ext0_pin_q & ~ext0_pin) : ~ext0_pin;
  assign ext1_ev = tcon_q[B_IT1] ? (ext1_pin_q & ~ext1_pin) : ~ext1_pin;
  assign pulse_edge = edge_sel_q[B_EXT2_EDGE] ?
                      (ce_pulse_in & ~pulse_q) :
                      (~ce_pulse_in & pulse_q);
  assign pulse_en = {sub_en_a_q[B_PX], sub_en_a_q[B_PY],
                     sub_en_b_q[B_PW_EN], sub_en_b_q[B_PV_EN]};
  assign ext2_ev = |(pulse_edge & pulse_en);
  assign ext3_ev = edge_sel_q[B_EXT3_EDGE] ?
                   (ce_busy_in & ~busy_q) :
                   (~ce_busy_in & busy_q);
  assign ext4_ev = (voltage_status_in != volt_q);
  // EEPROM busy is inverted, so its fall is a rising request edge.
  assign eeprom_fall = ~eeprom_busy_in & eeprom_q;
  assign spi_rise    = serial_periph_event_in & ~spi_q;
  assign ext5_ev = (eeprom_fall & sub_en_a_q[B_EEP]) |
                   (spi_rise & sub_en_b_q[B_SPI]);
  assign ext6_edge = ext6_src & ~ext6_src_q;
  assign ext6_en   = {sub_en_a_q[B_ALRM], sub_en_a_q[B_MIN],
                      sub_en_a_q[B_SEC], sub_en_a_q[B_XFER]};
  assign ext6_ev = |(ext6_edge & ext6_en);

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  // A hardware set always beats a clear in the same cycle, so a byte
  // mask write cannot lose an event that lands on it.
  logic [7:0] sub_a_set, sub_b_set, ext_flags_set, tcon_set;
  logic       take;
  assign take = irq_ack_in && irq_req_q;

  always_comb begin
    sub_a_set = '0;
    sub_a_set[B_XFER] = ext6_edge[0];
    sub_a_set[B_SEC]  = ext6_edge[1];
    sub_a_set[B_MIN]  = ext6_edge[2];
    sub_a_set[B_ALRM] = ext6_edge[3];
    sub_a_set[B_PY]   = pulse_edge[2];
    sub_a_set[B_PX]   = pulse_edge[3];
    sub_a_set[B_EEP]  = eeprom_fall;
    sub_b_set = '0;
    sub_b_set[B_SPI] = spi_rise;
    sub_b_set[B_PW]  = pulse_edge[1];
    sub_b_set[B_PV]  = pulse_edge[0];
    // Ones in a write keep the flag, zeros clear it.
    sub_a_d = (wr_sub_a ? (sub_a_q & sfr_wdata_in) : sub_a_q)
              | (sub_a_set & MASK_SUB_A);
    sub_b_d = (wr_sub_b ? (sub_b_q & sfr_wdata_in) : sub_b_q)
              | (sub_b_set & MASK_SUB_B);
  end

  always_comb begin
    ext_flags_set = '0;
    ext_flags_set[B_EXT2] = ext2_ev;
    ext_flags_set[B_EXT3] = ext3_ev;
    ext_flags_set[B_EXT4] = ext4_ev;
    ext_flags_set[B_EXT5] = ext5_ev;
    ext_flags_set[B_EXT6] = ext6_ev;
    ext_flags_d = wr_ext_flags ? sfr_wdata_in : ext_flags_q;
    if (take) begin
      case (src_q)
        SRC_EXT2: ext_flags_d[B_EXT2] = 1'b0;
        SRC_EXT3: ext_flags_d[B_EXT3] = 1'b0;
        SRC_EXT4: ext_flags_d[B_EXT4] = 1'b0;
        SRC_EXT5: ext_flags_d[B_EXT5] = 1'b0;
        SRC_EXT6: ext_flags_d[B_EXT6] = 1'b0;
        default:  ext_flags_d = ext_flags_d;
      endcase
    end
    ext_flags_d = (ext_flags_d | ext_flags_set) & MASK_EXT_FLAGS;
    tcon_set = '0;
    tcon_set[B_EXT0_FLAG] = ext0_ev;
    tcon_set[B_EXT1_FLAG] = ext1_ev;
    tcon_set[B_TMR0_OVF]  = timer_a_overflow_in;
    tcon_set[B_TMR1_OVF]  = timer_b_overflow_in;
    tcon_d = wr_tcon ? sfr_wdata_in : tcon_q;
    if (timer_a_service_ack_in) tcon_d[B_TMR0_OVF] = 1'b0;
    if (timer_b_service_ack_in) tcon_d[B_TMR1_OVF] = 1'b0;
    if (take && src_q == SRC_EXT0) tcon_d[B_EXT0_FLAG] = 1'b0;
    if (take && src_q == SRC_EXT1) tcon_d[B_EXT1_FLAG] = 1'b0;
    tcon_d = (tcon_d | tcon_set) & MASK_TIMER_EXT;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      tcon_q      <= RST_BYTE;
      ext_flags_q <= RST_BYTE;
      sub_a_q <= RST_BYTE;
      sub_b_q <= RST_BYTE;
    end else begin
      tcon_q      <= tcon_d;
      ext_flags_q <= ext_flags_d;
      sub_a_q <= sub_a_d;
      sub_b_q <= sub_b_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      en0_q <= RST_BYTE;
      en1_q <= RST_BYTE;
      en2_q <= RST_BYTE;
      ipl_q <= RST_BYTE;
      iph_q <= RST_BYTE;
      edge_sel_q <= RST_BYTE;
      sub_en_a_q <= RST_BYTE;
      sub_en_b_q <= RST_BYTE;
    end else begin
      if (wr_en0) en0_q <= sfr_wdata_in & MASK_ENABLE_0;
      if (wr_en1) en1_q <= sfr_wdata_in & MASK_ENABLE_1;
      if (wr_en2) en2_q <= sfr_wdata_in & MASK_ENABLE_2;
      if (wr_ipl) ipl_q <= sfr_wdata_in & MASK_PRIORITY;
      if (wr_iph) iph_q <= sfr_wdata_in & MASK_PRIORITY;
      if (wr_edge) edge_sel_q <= sfr_wdata_in & MASK_EDGE_SEL;
      if (wr_sub_en_a) sub_en_a_q <= sfr_wdata_in & MASK_SUB_A;
      if (wr_sub_en_b) sub_en_b_q <= sfr_wdata_in & MASK_SUB_EN_B;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      rdata_q <= RST_BYTE;
    end else if (sfr_rd_in) begin
      case (sfr_addr_in)
        ADDR_TIMER_EXT_CTRL:  rdata_q <= tcon_q;
        ADDR_ENABLE_0:        rdata_q <= en0_q;
        ADDR_ENABLE_1:        rdata_q <= en1_q;
        ADDR_ENABLE_2:        rdata_q <= en2_q;
        ADDR_PRIORITY_LOW:    rdata_q <= ipl_q;
        ADDR_PRIORITY_HIGH:   rdata_q <= iph_q;
        ADDR_EXT_REQ_FLAGS:   rdata_q <= ext_flags_q;
        ADDR_TIMER_C_CONTROL: rdata_q <= edge_sel_q;
        ADDR_SUB_FLAGS_A:     rdata_q <= sub_a_q;
        ADDR_SUB_FLAGS_B:     rdata_q <= sub_b_q;
        ADDR_SUB_ENABLES_A:   rdata_q <= sub_en_a_q;
        ADDR_SUB_ENABLES_B:   rdata_q <= sub_en_b_q;
        default:              rdata_q <= RST_BYTE;
      endcase
    end
  end
  assign sfr_rdata_out = rdata_q;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] active;
  logic [LVL_W-1:0]   src_level [NUM_SRC];
  always_comb begin
    active[SRC_EXT0] = tcon_q[B_EXT0_FLAG] & en0_q[B_EXT0_EN];
    active[SRC_SER1] = serial1_req_in & en2_q[B_ES1];
    active[SRC_TMR0] = tcon_q[B_TMR0_OVF] & en0_q[B_ET0];
    active[SRC_EXT2] = ext_flags_q[B_EXT2] & en1_q[B_EXT2];
    active[SRC_EXT1] = tcon_q[B_EXT1_FLAG] & en0_q[B_EXT1_EN];
    active[SRC_EXT3] = ext_flags_q[B_EXT3] & en1_q[B_EXT3];
    active[SRC_TMR1] = tcon_q[B_TMR1_OVF] & en0_q[B_ET1];
    active[SRC_EXT4] = ext_flags_q[B_EXT4] & en1_q[B_EXT4];
    active[SRC_SER0] = serial0_req_in & en0_q[B_ES0];
    active[SRC_EXT5] = ext_flags_q[B_EXT5] & en1_q[B_EXT5];
    active[SRC_EXT6] = ext_flags_q[B_EXT6] & en1_q[B_EXT6];
  end

  // Group of a source is its polling index halved.
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_level
    assign src_level[i] = {iph_q[i/2], ipl_q[i/2]};
  end

  logic             found, any_isr, allow;
  logic [SRC_W-1:0] win_src;
  logic [LVL_W-1:0] win_lvl, cur_lvl;
  always_comb begin
    found   = 1'b0;
    win_src = '0;
    win_lvl = '0;
    for (int l = NUM_LVL - 1; l >= 0; l--) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (!found && active[s] && src_level[s] == l[LVL_W-1:0]) begin
          found   = 1'b1;
          win_src = s[SRC_W-1:0];
          win_lvl = l[LVL_W-1:0];
        end
      end
    end
    any_isr = |in_service_q;
    cur_lvl = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (in_service_q[l]) cur_lvl = l[LVL_W-1:0];
    end
  end
  // A running handler is only interrupted by a strictly higher level.
  assign allow = en0_q[B_GLOBAL] && found &&
                 (!any_isr || win_lvl > cur_lvl);

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      irq_req_q <= 1'b0;
      vector_q  <= '0;
      src_q     <= '0;
      level_q   <= '0;
    end else begin
      // Drop the request for a cycle after a take so a stale flag is
      // never offered twice.
      irq_req_q <= allow && !take;
      vector_q  <= vector_of(win_src);
      src_q     <= win_src;
      level_q   <= win_lvl;
    end
  end

  // Return releases the highest level that is in service.
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      in_service_q <= '0;
    end else if (take) begin
      in_service_q[level_q] <= 1'b1;
    end else if (irq_return_in && any_isr) begin
      in_service_q[cur_lvl] <= 1'b0;
    end
  end

  assign irq_req_out    = irq_req_q;
  assign irq_vector_out = vector_q;
  assign irq_source_out = src_q;
  assign irq_level_out  = level_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_unused_flags: assert property (
    (ext_flags_q & ~MASK_EXT_FLAGS) == 8'h00)
    else $error("unused request flag bit set");
  a_timer_ack: assert property (
    timer_a_service_ack_in && !timer_a_overflow_in |=> !tcon_q[B_TMR0_OVF])
    else $error("timer flag not cleared on ack");
  a_volt_change: assert property (
    voltage_status_in != volt_q |=> ext_flags_q[B_EXT4])
    else $error("voltage change did not flag ext4");
  a_xfer_fall: assert property (
    $fell(transfer_busy_in) |-> ##1 sub_a_q[B_XFER])
    else $error("transfer fall did not set sub flag");
  a_ones_keep: assert property (
    wr_sub_a && sub_a_q[B_SEC] && sfr_wdata_in[B_SEC] |=> sub_a_q[B_SEC])
    else $error("written one cleared sub flag");
  a_zero_clears: assert property (
    wr_sub_a && !sfr_wdata_in[B_MIN] && !sub_a_set[B_MIN]
    |=> !sub_a_q[B_MIN])
    else $error("written zero did not clear sub flag");
  a_auto_clear: assert property (
    take && src_q == SRC_EXT3 && !ext3_ev && !wr_ext_flags
    |=> !ext_flags_q[B_EXT3])
    else $error("ext3 flag not cleared on vector");
  a_global_gate: assert property (
    !en0_q[B_GLOBAL] |=> !irq_req_q)
    else $error("request while globally disabled");
  a_vector_map: assert property (
    irq_req_q |-> irq_vector_out == vector_of(irq_source_out))
    else $error("vector does not match source");
  a_preempt_lvl: assert property (
    irq_req_q && $past(any_isr) |-> level_q > $past(cur_lvl))
    else $error("preemption by equal or lower level");
  a_tie_order: assert property (
    active[SRC_EXT0] && active[SRC_EXT6] && en0_q[B_GLOBAL] && !any_isr
    && !take && src_level[SRC_EXT0] == src_level[SRC_EXT6]
    |=> irq_req_q && src_q != SRC_EXT6)
    else $error("polling order not honoured");

  c_preempt: cover property (irq_req_q && any_isr);
  c_ext6_take: cover property (take && src_q == SRC_EXT6);
  c_tie: cover property (active[SRC_EXT2] && active[SRC_TMR0]);
  c_return: cover property (irq_return_in && in_service_q[3]);

endmodule // mpu_interrupt_aggregator

//--- core/mpu_irq_pkg.sv
// Summary of operation
// - Request flags: ext2-6 in bits 1-5.
// - Timer overflow flags clear on service acknowledge.
// - Ext6 sources and EEPROM busy inverted for rising detection.
// - Ext0-4 wired to I/O, pulse, busy, voltage.
// - Ext5 from EEPROM fall or serial-peripheral rise.
// - Ext6 from transfer, second, minute, alarm falls.
// - Ext0/ext1 taken from selectable I/O pins.
// - Delivery needs enable; hardware sets each flag.
// - Sub-sources carry own enable and flag bits.
// - Ext6 sub-source bit placement 0,1,2,4.
// - Pulse X/Y bits 6/5; W/V flags 4/3.
// - Ext0-6 flags clear when vectored.
// - Sub-flags clear by written zero only.
// - Six priority groups: five source pairs, ext6 alone.
// - Group level from high/low priority bits.
// - Fixed polling order breaks equal-level ties.
// - Preemption only by strictly higher level.
// - Polarity bit: 0 falling, 1 rising.
// - Global enable low blocks all interrupts.
// - Each source has its fixed vector.
package mpu_irq_pkg;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned NUM_SRC = 11;
  localparam int unsigned SRC_W   = 4;
  localparam int unsigned LVL_W   = 2;
  localparam int unsigned NUM_LVL = 4;
  localparam int unsigned VEC_W   = 16;

  localparam logic [15:0] ADDR_TIMER_EXT_CTRL   = 16'h0088;
  localparam logic [15:0] ADDR_ENABLE_2         = 16'h009A;
  localparam logic [15:0] ADDR_ENABLE_0         = 16'h00A8;
  localparam logic [15:0] ADDR_PRIORITY_LOW     = 16'h00A9;
  localparam logic [15:0] ADDR_ENABLE_1         = 16'h00B8;
  localparam logic [15:0] ADDR_PRIORITY_HIGH    = 16'h00B9;
  localparam logic [15:0] ADDR_EXT_REQ_FLAGS    = 16'h00C0;
  localparam logic [15:0] ADDR_TIMER_C_CONTROL  = 16'h00C8;
  localparam logic [15:0] ADDR_SUB_FLAGS_A      = 16'h00E8;
  localparam logic [15:0] ADDR_SUB_FLAGS_B      = 16'h00F8;
  localparam logic [15:0] ADDR_SUB_ENABLES_A    = 16'h2700;
  localparam logic [15:0] ADDR_SUB_ENABLES_B    = 16'h2701;

  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [7:0] MASK_EXT_FLAGS  = 8'h3E;
  localparam logic [7:0] MASK_TIMER_EXT  = 8'hAF;
  localparam logic [7:0] MASK_ENABLE_0   = 8'h9F;
  localparam logic [7:0] MASK_ENABLE_1   = 8'h3E;
  localparam logic [7:0] MASK_ENABLE_2   = 8'h01;
  localparam logic [7:0] MASK_PRIORITY   = 8'h3F;
  localparam logic [7:0] MASK_EDGE_SEL   = 8'h60;
  localparam logic [7:0] MASK_SUB_A      = 8'hF7;
  localparam logic [7:0] MASK_SUB_B      = 8'h98;
  localparam logic [7:0] MASK_SUB_EN_B   = 8'hE0;

  // Bit positions in the timer/external control byte.
  localparam int unsigned B_TMR1_OVF  = 7;
  localparam int unsigned B_TMR0_OVF  = 5;
  localparam int unsigned B_EXT1_FLAG = 3;
  localparam int unsigned B_IT1       = 2;
  localparam int unsigned B_EXT0_FLAG = 1;
  localparam int unsigned B_IT0       = 0;
  // Bit positions in the enable bytes and the edge select byte.
  localparam int unsigned B_GLOBAL = 7;
  localparam int unsigned B_ES0    = 4;
  localparam int unsigned B_ET1    = 3;
  localparam int unsigned B_EXT1_EN = 2;
  localparam int unsigned B_ET0    = 1;
  localparam int unsigned B_EXT0_EN = 0;
  localparam int unsigned B_ES1    = 0;
  localparam int unsigned B_EXT2   = 1;
  localparam int unsigned B_EXT3   = 2;
  localparam int unsigned B_EXT4   = 3;
  localparam int unsigned B_EXT5   = 4;
  localparam int unsigned B_EXT6   = 5;
  localparam int unsigned B_EXT3_EDGE = 6;
  localparam int unsigned B_EXT2_EDGE = 5;
  // Sub-source bit positions.
  localparam int unsigned B_XFER = 0;
  localparam int unsigned B_SEC  = 1;
  localparam int unsigned B_MIN  = 2;
  localparam int unsigned B_ALRM = 4;
  localparam int unsigned B_PY   = 5;
  localparam int unsigned B_PX   = 6;
  localparam int unsigned B_EEP  = 7;
  localparam int unsigned B_SPI  = 7;
  localparam int unsigned B_PW   = 4;
  localparam int unsigned B_PV   = 3;
  localparam int unsigned B_PW_EN = 6;
  localparam int unsigned B_PV_EN = 5;

  // Sources in polling order; group of a source is its index halved.
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_SER1 = 4'h1;
  localparam logic [3:0] SRC_TMR0 = 4'h2;
  localparam logic [3:0] SRC_EXT2 = 4'h3;
  localparam logic [3:0] SRC_EXT1 = 4'h4;
  localparam logic [3:0] SRC_EXT3 = 4'h5;
  localparam logic [3:0] SRC_TMR1 = 4'h6;
  localparam logic [3:0] SRC_EXT4 = 4'h7;
  localparam logic [3:0] SRC_SER0 = 4'h8;
  localparam logic [3:0] SRC_EXT5 = 4'h9;
  localparam logic [3:0] SRC_EXT6 = 4'hA;

  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TMR0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TMR1 = 16'h001B;
  localparam logic [15:0] VEC_SER0 = 16'h0023;
  localparam logic [15:0] VEC_EXT2 = 16'h004B;
  localparam logic [15:0] VEC_EXT3 = 16'h0053;
  localparam logic [15:0] VEC_EXT4 = 16'h005B;
  localparam logic [15:0] VEC_EXT5 = 16'h0063;
  localparam logic [15:0] VEC_EXT6 = 16'h006B;
  localparam logic [15:0] VEC_SER1 = 16'h0083;
endpackage

//--- test/core_model.sv
`timescale 1ns/1ns
module core_model #(
  parameter int unsigned HOLD = 4
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic req_in,
  output logic      ack_out,
  output logic      ret_out
);
  logic [3:0] cnt_q;
  // The handler stays busy HOLD cycles, so a waiting request must queue.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      ret_out <= 1'b0;
      cnt_q   <= 4'h0;
    end else begin
      ack_out <= req_in && !ack_out && cnt_q == 4'h0;
      ret_out <= cnt_q == 4'h1;
      if (ack_out) begin
        cnt_q <= HOLD[3:0];
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // core_model

//--- test/test_mpu_interrupt_aggregator.sv
`timescale 1ns/1ns
module test_mpu_interrupt_aggregator;
  import mpu_irq_pkg::*;
  logic ref_clk_in = 1'b0, reset_n_in = 1'b0, sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0, ce_busy_in = 1'b0, eeprom_busy_in = 1'b0;
  logic [15:0] sfr_addr_in = 16'h0000;
  logic [7:0] sfr_wdata_in = 8'h00, sfr_rdata_out, rd_v, dio_pins_in = 8'hFF;
  logic [2:0] ext0_pin_select_in = 3'h0, ext1_pin_select_in = 3'h1;
  logic [2:0] voltage_status_in = 3'h0;
  logic [3:0] ce_pulse_in = 4'h0, irq_source_out;
  logic serial_periph_event_in = 1'b0, transfer_busy_in = 1'b0;
  logic clock_second_tick_in = 1'b0, clock_minute_tick_in = 1'b0;
  logic clock_alarm_in = 1'b0, timer_a_overflow_in = 1'b0;
  logic timer_b_overflow_in = 1'b0, timer_a_service_ack_in = 1'b0;
  logic timer_b_service_ack_in = 1'b0, serial0_req_in = 1'b0;
  logic serial1_req_in = 1'b0, irq_ack_in, irq_return_in, irq_req_out;
  logic [15:0] irq_vector_out;
  logic [1:0] irq_level_out;
  int miscompares = 0;
  int checks_done = 0;
  logic [15:0] tab_a [10] = '{16'h00A9, 16'h00B9, 16'h00B8, 16'h00C0,
    16'h00C8, 16'h00E8, 16'h00F8, 16'h2700, 16'h2701, 16'h1234};
  logic [7:0] tab_m [10] = '{8'h3F, 8'h3F, 8'h3E, 8'h3E, 8'h60, 8'h00,
    8'h00, 8'hF7, 8'hE0, 8'h00};
  always #5 ref_clk_in = ~ref_clk_in;
  mpu_interrupt_aggregator dut (.*);
  core_model core (.clk_in(ref_clk_in), .rst_n_in(reset_n_in),
    .req_in(irq_req_out), .ack_out(irq_ack_in), .ret_out(irq_return_in));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, errors %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(negedge ref_clk_in);
    sfr_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge ref_clk_in);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(negedge ref_clk_in);
    sfr_rd_in = 1'b0;
    rd_v = sfr_rdata_out;
  endtask
  task automatic wait_req();
    int n = 0;
    while (irq_req_out !== 1'b1 && n < 50) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n == 50) begin
      miscompares++;
      end_sim();
    end
  endtask
  initial begin
    repeat (5) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(tab_a[i]);
      chk(rd_v, 8'h00);
      wr(tab_a[i], 8'hFF);
      rd(tab_a[i]);
      chk(rd_v, tab_m[i]);
    end
    wr(16'h00A9, 8'h04);
    wr(16'h00B9, 8'h00);
    wr(16'h00C0, 8'h00);
    wr(16'h00B8, 8'h06);
    wr(16'h00C8, 8'h00);
    wr(16'h2700, 8'h40);
    wr(16'h2701, 8'h00);
    wr(16'h00A8, 8'h80);
    ce_pulse_in = 4'h8;
    ce_busy_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    ce_pulse_in = 4'h0;
    ce_busy_in = 1'b0;
    wait_req();
    chk(irq_vector_out, 16'h0053);
    chk(irq_level_out, 2'h1);
    repeat (4) @(negedge ref_clk_in);
    chk(irq_req_out, 1'b0);
    wait_req();
    chk(irq_vector_out, 16'h004B);
    chk(irq_source_out, 4'h3);
    repeat (3) @(negedge ref_clk_in);
    rd(16'h00C0);
    chk(rd_v, 8'h00);
    rd(16'h00E8);
    chk(rd_v, 8'h40);
    wr(16'h00E8, 8'hFF);
    rd(16'h00E8);
    chk(rd_v, 8'h40);
    wr(16'h00E8, 8'hBF);
    rd(16'h00E8);
    chk(rd_v, 8'h00);
    timer_a_overflow_in = 1'b1;
    @(negedge ref_clk_in);
    timer_a_overflow_in = 1'b0;
    rd(16'h0088);
    chk(rd_v & 8'hA0, 8'h20);
    timer_a_service_ack_in = 1'b1;
    @(negedge ref_clk_in);
    timer_a_service_ack_in = 1'b0;
    rd(16'h0088);
    chk(rd_v & 8'hA0, 8'h00);
    transfer_busy_in = 1'b1;
    clock_second_tick_in = 1'b1;
    @(negedge ref_clk_in);
    transfer_busy_in = 1'b0;
    clock_second_tick_in = 1'b0;
    rd(16'h00E8);
    chk(rd_v, 8'h03);
    wr(16'h00E8, 8'hFE);
    rd(16'h00E8);
    chk(rd_v, 8'h02);
    ext0_pin_select_in = 3'h2;
    wr(16'h0088, 8'h01);
    wr(16'h00A8, 8'h81);
    dio_pins_in = 8'hFB;
    wait_req();
    chk(irq_vector_out, 16'h0003);
    chk(irq_source_out, 4'h0);
    repeat (3) @(negedge ref_clk_in);
    rd(16'h0088);
    chk(rd_v & 8'h02, 8'h00);
    reset_n_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    chk(irq_req_out, 1'b0);
    rd(16'h00A8);
    chk(rd_v, 8'h00);
    end_sim();
  end
endmodule // test_mpu_interrupt_aggregator
